// >>> shared/uhr_pkg.sv
// constants shared by the serial port register block
// assumes a single 200 MHz system clock domain
package uhr_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [2:0] UHR_OFF_DATA = 3'h0;
  localparam logic [2:0] UHR_OFF_IER = 3'h1;
  localparam logic [2:0] UHR_OFF_FCR_IIR = 3'h2;
  localparam logic [2:0] UHR_OFF_LCR = 3'h3;
  localparam logic [2:0] UHR_OFF_MCR = 3'h4;
  localparam logic [2:0] UHR_OFF_LSR = 3'h5;
  localparam logic [2:0] UHR_OFF_MSR = 3'h6;
  localparam logic [2:0] UHR_OFF_SCR = 3'h7;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int UHR_BANK_BIT = 7;
  localparam int UHR_IE_MS = 3;
  localparam int UHR_IE_LS = 2;
  localparam int UHR_IE_THR = 1;
  localparam int UHR_IE_RDA = 0;
  localparam logic [7:0] UHR_LSR_RESET = 8'h60;
  localparam logic [7:0] UHR_IIR_RESET = 8'h01;
  localparam logic [3:0] UHR_ID_NONE = 4'h1;
  localparam logic [3:0] UHR_ID_LINE = 4'h6;
  localparam logic [3:0] UHR_ID_RDA = 4'h4;
  localparam logic [3:0] UHR_ID_TIMEOUT = 4'hC;
  localparam logic [3:0] UHR_ID_THRE = 4'h2;
  localparam logic [3:0] UHR_ID_MODEM = 4'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int UHR_SYS_CLK_KHZ = 200000;
  localparam int UHR_PRESCALE = 13;
  // 200 MHz stands in for 24 MHz; prescaler ratio scaled to 108, giving 1.8519 MHz in place of 1.8462 MHz
  localparam int UHR_REF_CLK_KHZ = 24000;
  localparam int UHR_PRESCALE_SYS = (UHR_PRESCALE * UHR_SYS_CLK_KHZ) / UHR_REF_CLK_KHZ;
  localparam int UHR_TIMEOUT_CHARS = 4;

  typedef enum logic [1:0] {UHR_TX_IDLE, UHR_TX_SHIFT} uhr_tx_state_t;
  typedef enum logic [1:0] {UHR_RX_IDLE, UHR_RX_SHIFT} uhr_rx_state_t;

endpackage : uhr_pkg

// >>> rtl/uhr_fifo.sv
// parameterised first-in first-out buffer with valid/ready on both sides
// assumes synchronous active-low reset and one clock
`timescale 1ns/10ps
module uhr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } uhr_fifo_st_t;
  uhr_fifo_st_t st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data = mem[st.rd];
  assign level = st.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer bookkeeping
  always_comb begin
    next_st = st;
    if (flush) begin
      next_st = '0;
    end else begin
      if (push) next_st.wr = st.wr + 1'b1;
      if (pop) next_st.rd = st.rd + 1'b1;
      next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage has no reset; only pointers define content
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
      if (push && !flush) mem[st.wr] <= in_data;
    end
  end
endmodule : uhr_fifo

// >>> rtl/uhr_uart.sv
// serial port register block with banked map, baud generator and serialiser
// assumes host strobes already synchronous to sys_clk, one cycle per access
`timescale 1ns/10ps

// Behaviour
// [RULE1] line control bit 7 selects the bank at offsets 0 and 1
// [RULE2] offset 0: write loads transmit, read returns receive; bank set gives divisor low
// [RULE3] offset 1: interrupt enable, or divisor high when bank bit set
// [RULE4] characters shift out and in least significant bit first
// [RULE5] baud generator divides by the 16-bit divisor, giving sixteen times bit rate
// [RULE6] baud input clock is 1.8462 MHz, the device clock divided by 13; here 200 MHz divided by 108 gives 1.8519 MHz
// [RULE7] enable bit 3 raises modem-status interrupt on any modem status change
// [RULE8] enable bit 2 interrupts on overrun, parity, framing, break; software reads status
// [RULE9] enable bit 1 interrupts when the transmit holding register empties
// [RULE10] enable bit 0 interrupts on data available and, with fifos, timeout
// [RULE11] line status reads 0x60 after reset
// [RULE12] interrupt identification reads 0x01 after reset
// [RULE13] fifo control is write only; fifo use not supported during dma
// [RULE14] identification ranks line status, receive/timeout, transmit empty, modem status
// [RULE15] interrupt output high while any enabled source is pending
// [RULE16] interrupt enable bits 7 to 4 read zero and ignore writes
module uhr_uart #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // host register port
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic dma_active,
  // serial and modem pins
  output logic ser_out,
  input wire logic ser_in,
  input wire logic [3:0] modem_in,
  output logic [3:0] modem_out,
  // interrupt
  output logic irq
);
  import uhr_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] lcr;
    logic [3:0] ier;
    logic [15:0] div;
    logic [4:0] mcr;
    logic [7:0] scr;
    logic fifo_en;
    logic [1:0] trig;
    logic [7:0] rdata;
    logic [6:0] pre_cnt;
    logic [15:0] baud_cnt;
    logic tick;
    uhr_tx_state_t tx_st;
    logic [3:0] tx_sub;
    logic [3:0] tx_bit;
    logic [10:0] tx_sh;
    logic tx_out;
    uhr_rx_state_t rx_st;
    logic [3:0] rx_sub;
    logic [3:0] rx_bit;
    logic [10:0] rx_sh;
    logic rx_prev;
    logic oe, pe, fe, bi;
    logic thre_pend;
    logic [3:0] msr_prev;
    logic [3:0] msr_delta;
    logic [9:0] to_cnt;
  } uhr_st_t;
  uhr_st_t s, n;

  logic bank;
  logic txf_in_ready, txf_out_valid, txf_pop;
  logic [7:0] txf_out_data;
  logic rxf_push, rxf_in_ready, rxf_out_valid, rxf_pop;
  logic [10:0] rxf_out_data, rxf_in_data;
  logic [$clog2(FIFO_DEPTH):0] rxf_level, txf_level;
  logic tx_flush, rx_flush;
  logic data_rdy, temt, thre, ls_pend, rda_pend, to_pend, ms_pend;
  logic [3:0] ident;
  logic [3:0] nbits;
  logic [7:0] lsr_val, msr_val;
  logic [4:0] trig_lvl;
  logic wr_data, rd_data;
  logic [7:0] rd_mux;

  assign bank = s.lcr[UHR_BANK_BIT]; // RULE1
  assign wr_data = reg_wr && reg_addr == UHR_OFF_DATA && !bank; // RULE2
  assign rd_data = reg_rd && reg_addr == UHR_OFF_DATA && !bank; // RULE2
  // fifo resets are self-clearing: only the write strobe itself flushes
  assign tx_flush = reg_wr && reg_addr == UHR_OFF_FCR_IIR && (reg_wdata[2] || !reg_wdata[0]);
  assign rx_flush = reg_wr && reg_addr == UHR_OFF_FCR_IIR && (reg_wdata[1] || !reg_wdata[0]);
  assign nbits = 4'd5 + {2'b00, s.lcr[1:0]};

  // ****************************************
  // data buffers
  // ****************************************
  // the host always goes through FIFO_DEPTH-entry buffers, even with fifos off
  uhr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txf (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .flush(tx_flush),
    .in_valid(wr_data), .in_ready(txf_in_ready), .in_data(reg_wdata),
    .out_valid(txf_out_valid), .out_ready(txf_pop), .out_data(txf_out_data),
    .level(txf_level)
  );
  uhr_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH)) u_rxf (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .flush(rx_flush),
    .in_valid(rxf_push), .in_ready(rxf_in_ready), .in_data(rxf_in_data),
    .out_valid(rxf_out_valid), .out_ready(rxf_pop), .out_data(rxf_out_data),
    .level(rxf_level)
  );
  assign rxf_pop = rd_data;
  assign data_rdy = rxf_out_valid;
  assign temt = !txf_out_valid && s.tx_st == UHR_TX_IDLE;
  assign thre = s.fifo_en ? !txf_out_valid : !txf_out_valid;
  assign txf_pop = s.tx_st == UHR_TX_IDLE && s.tick;

  // ****************************************
  // status and interrupt ranking
  // ****************************************
  always_comb begin
    case (s.trig)
      2'd0: trig_lvl = 5'd1;
      2'd1: trig_lvl = 5'd4;
      2'd2: trig_lvl = 5'd8;
      default: trig_lvl = 5'd14;
    endcase
  end
  assign lsr_val = {1'b0, temt, thre, s.bi, s.fe, s.pe, s.oe, data_rdy}; // RULE11
  assign msr_val = {modem_in, s.msr_delta};
  assign ls_pend = s.ier[UHR_IE_LS] && (s.oe || s.pe || s.fe || s.bi); // RULE8
  assign rda_pend = s.ier[UHR_IE_RDA] &&
    (s.fifo_en ? rxf_level >= ($clog2(FIFO_DEPTH)+1)'(trig_lvl) : data_rdy); // RULE10
  assign to_pend = s.ier[UHR_IE_RDA] && s.fifo_en && data_rdy &&
    s.to_cnt == '1; // RULE10
  assign ms_pend = s.ier[UHR_IE_MS] && s.msr_delta != '0; // RULE7
  // priority chain mirrors the identification table
  always_comb begin
    if (ls_pend) ident = UHR_ID_LINE; // RULE14
    else if (to_pend) ident = UHR_ID_TIMEOUT;
    else if (rda_pend) ident = UHR_ID_RDA;
    else if (s.ier[UHR_IE_THR] && s.thre_pend) ident = UHR_ID_THRE; // RULE9
    else if (ms_pend) ident = UHR_ID_MODEM;
    else ident = UHR_ID_NONE; // RULE12
  end
  assign irq = !ident[0]; // RULE15

  // ****************************************
  // register read mux
  // ****************************************
  // kept apart from the state copy so only one process writes it
  always_comb begin
    if (reg_addr == UHR_OFF_DATA) begin
      rd_mux = bank ? s.div[7:0] : rxf_out_data[7:0]; // RULE2
    end else if (reg_addr == UHR_OFF_IER) begin
      rd_mux = bank ? s.div[15:8] : {4'h0, s.ier}; // RULE3 RULE16
    end else if (reg_addr == UHR_OFF_FCR_IIR) begin
      rd_mux = {s.fifo_en, s.fifo_en, 2'b00, ident}; // RULE13
    end else if (reg_addr == UHR_OFF_LCR) begin
      rd_mux = s.lcr;
    end else if (reg_addr == UHR_OFF_MCR) begin
      rd_mux = {3'b000, s.mcr};
    end else if (reg_addr == UHR_OFF_LSR) begin
      rd_mux = lsr_val;
    end else if (reg_addr == UHR_OFF_MSR) begin
      rd_mux = msr_val;
    end else begin
      rd_mux = s.scr;
    end
  end
  assign reg_rdata = s.rdata;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    {n.lcr, n.ier, n.div, n.mcr, n.scr, n.fifo_en, n.trig} =
      {s.lcr, s.ier, s.div, s.mcr, s.scr, s.fifo_en, s.trig};
    n.rdata = rd_mux;
    {n.pre_cnt, n.baud_cnt, n.tick} = {s.pre_cnt, s.baud_cnt, 1'b0};
    {n.tx_st, n.tx_sub, n.tx_bit, n.tx_sh, n.tx_out} =
      {s.tx_st, s.tx_sub, s.tx_bit, s.tx_sh, s.tx_out};
    {n.rx_st, n.rx_sub, n.rx_bit, n.rx_sh, n.rx_prev} =
      {s.rx_st, s.rx_sub, s.rx_bit, s.rx_sh, ser_in};
    {n.oe, n.pe, n.fe, n.bi, n.thre_pend} = {s.oe, s.pe, s.fe, s.bi, s.thre_pend};
    n.msr_prev = modem_in;
    n.msr_delta = s.msr_delta | (modem_in ^ s.msr_prev); // RULE7
    n.to_cnt = s.to_cnt;
    rxf_push = 1'b0;
    rxf_in_data = '0;
    // prescaler then divisor: 16x bit clock
    if (s.pre_cnt == 7'(UHR_PRESCALE_SYS - 1)) begin // RULE6
      n.pre_cnt = '0;
      if (s.baud_cnt >= s.div - 16'd1 || s.div == '0) begin // RULE5
        n.baud_cnt = '0;
        n.tick = 1'b1;
      end else begin
        n.baud_cnt = s.baud_cnt + 16'd1;
      end
    end else begin
      n.pre_cnt = s.pre_cnt + 7'd1;
    end
    // transmitter: start driven directly; data, parity, stop in shift register
    case (s.tx_st)
      UHR_TX_IDLE: begin
        if (txf_pop && txf_out_valid) begin
          n.tx_sh = {2'b11, ^txf_out_data ^ ~s.lcr[4], txf_out_data};
          if (s.lcr[5]) n.tx_sh[8] = ~s.lcr[4];
          n.tx_st = UHR_TX_SHIFT;
          n.tx_sub = '0;
          n.tx_bit = '0;
          n.tx_out = 1'b0;
          n.thre_pend = !(txf_level > 1); // RULE9
        end
      end
      UHR_TX_SHIFT: begin
        if (s.tick) begin
          n.tx_sub = s.tx_sub + 4'd1;
          if (s.tx_sub == 4'hF) begin
            n.tx_bit = s.tx_bit + 4'd1;
            if (s.tx_bit < nbits) n.tx_out = s.tx_sh[s.tx_bit]; // RULE4
            else if (s.tx_bit == nbits && s.lcr[3]) n.tx_out = s.tx_sh[8];
            else n.tx_out = 1'b1;
            // idle only after the last stop bit has stood a full bit time
            if (s.tx_bit == nbits + {3'b000, s.lcr[3]} + {3'b000, s.lcr[2]} + 4'd1) begin
              n.tx_st = UHR_TX_IDLE;
            end
          end
        end
      end
      default: n.tx_st = UHR_TX_IDLE;
    endcase
    // receiver: sample mid-bit, assemble lsb first
    case (s.rx_st)
      UHR_RX_IDLE: begin
        if (s.tick && !ser_in) begin
          n.rx_st = UHR_RX_SHIFT;
          n.rx_sub = 4'd1;
          n.rx_bit = '0;
          n.rx_sh = '0;
        end
      end
      UHR_RX_SHIFT: begin
        if (s.tick) begin
          n.rx_sub = s.rx_sub + 4'd1;
          if (s.rx_sub == 4'd7) begin
            n.rx_bit = s.rx_bit + 4'd1;
            if (s.rx_bit != '0) n.rx_sh[s.rx_bit - 4'd1] = ser_in; // RULE4
            if (s.rx_bit == nbits + {3'b000, s.lcr[3]} + 4'd1) begin
              n.rx_st = UHR_RX_IDLE;
              rxf_push = 1'b1;
              rxf_in_data = n.rx_sh;
              n.fe = s.fe | !ser_in; // RULE8
              n.bi = s.bi | (!ser_in && n.rx_sh == '0);
              n.pe = s.pe | (s.lcr[3] && (^n.rx_sh[7:0] ^ n.rx_sh[nbits] ^ ~s.lcr[4]));
              n.oe = s.oe | !rxf_in_ready;
              n.to_cnt = '0;
            end
          end
        end
      end
      default: n.rx_st = UHR_RX_IDLE;
    endcase
    // character timeout counts ticks while data sits unread
    if (!data_rdy || rd_data) n.to_cnt = '0;
    else if (s.tick && s.to_cnt != '1) n.to_cnt = s.to_cnt + 10'd1;
    // host writes
    if (reg_wr) begin
      if (reg_addr == UHR_OFF_DATA && bank) n.div[7:0] = reg_wdata; // RULE2
      else if (reg_addr == UHR_OFF_DATA) n.thre_pend = 1'b0;
      else if (reg_addr == UHR_OFF_IER && bank) n.div[15:8] = reg_wdata; // RULE3
      else if (reg_addr == UHR_OFF_IER) n.ier = reg_wdata[3:0]; // RULE16
      else if (reg_addr == UHR_OFF_FCR_IIR && !dma_active) begin // RULE13
        n.fifo_en = reg_wdata[0];
        n.trig = reg_wdata[7:6];
      end
      else if (reg_addr == UHR_OFF_LCR) n.lcr = reg_wdata;
      else if (reg_addr == UHR_OFF_MCR) n.mcr = reg_wdata[4:0];
      else if (reg_addr == UHR_OFF_SCR) n.scr = reg_wdata;
    end
    // read side effects; set wins over clear for new changes
    if (reg_rd && reg_addr == UHR_OFF_LSR) begin
      {n.oe, n.pe, n.fe, n.bi} = rxf_push ? {n.oe, n.pe, n.fe, n.bi} : 4'h0;
    end
    if (reg_rd && reg_addr == UHR_OFF_MSR) n.msr_delta = modem_in ^ s.msr_prev;
    if (reg_rd && reg_addr == UHR_OFF_FCR_IIR && ident == UHR_ID_THRE) n.thre_pend = 1'b0;
  end

  // reset state: lsr 0x60 and iir 0x01 follow from empty buffers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s <= '0;
      s.tx_out <= 1'b1;
      s.rx_prev <= 1'b1;
    end else if (clk_en) begin
      s <= n;
    end
  end

  // loop mode holds the line idle and not broken by break control
  assign ser_out = s.mcr[4] ? 1'b1 : (s.tx_out && !s.lcr[6]);
  assign modem_out = s.mcr[3:0];
endmodule : uhr_uart

// >>> tb/uhr_uart_props.sv
// port assertions for the serial port register block
// assumes one clock, clk_en held high by the bench
`timescale 1ns/10ps
module uhr_uart_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // host side
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // pins
  input wire logic ser_out,
  input wire logic [3:0] modem_in,
  input wire logic irq
);
  logic bank;
  logic [3:0] ier_sh;
  // ****************************************
  // shadows of bank bit and enables
  // ****************************************
  // updated on the same edge as the real registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bank <= 1'b0;
      ier_sh <= 4'h0;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == 3'h3) bank <= reg_wdata[7];
      if (reg_addr == 3'h1 && !bank) ier_sh <= reg_wdata[3:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_div_back;
    logic [7:0] v;
    (clk_en && reg_wr && reg_addr == 3'h0 && bank, v = reg_wdata)
      ##1 !reg_wr ##1 (clk_en && reg_rd && !reg_wr && reg_addr == 3'h0 && bank)
      |=> reg_rdata == v;
  endproperty
  a_div_back: assert property (p_div_back) else $error("divisor low readback");
  property p_en_hi;
    clk_en && reg_rd && reg_addr == 3'h1 && !bank |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_en_hi: assert property (p_en_hi) else $error("enable top bits");
  property p_en_back;
    clk_en && reg_rd && !reg_wr && reg_addr == 3'h1 && !bank |=> reg_rdata[3:0] == $past(ier_sh);
  endproperty
  a_en_back: assert property (p_en_back) else $error("enable readback");
  property p_irq_off;
    ier_sh == 4'h0 |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without enables");
  property p_noint;
    clk_en && reg_rd && !reg_wr && reg_addr == 3'h2 |=> reg_rdata[0] == !$past(irq);
  endproperty
  a_noint: assert property (p_noint) else $error("pending flag vs irq");
  property p_modem_irq;
    ier_sh[3] && modem_in != $past(modem_in) |-> ##[0:4] irq;
  endproperty
  a_modem_irq: assert property (p_modem_irq) else $error("modem change no irq");
  property p_idle;
    $rose(resetn) |-> ser_out && !irq;
  endproperty
  a_idle: assert property (p_idle) else $error("not idle after reset");
  property p_codes;
    clk_en && reg_rd && !reg_wr && reg_addr == 3'h2
      |=> reg_rdata[5:4] == 2'h0 && reg_rdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hC, 4'h2, 4'h0};
  endproperty
  a_codes: assert property (p_codes) else $error("bad ident code");
  property p_rda_irq;
    (clk_en && reg_rd && !reg_wr && reg_addr == 3'h5) ##1 (reg_rdata[0] && ier_sh[0]) |-> irq;
  endproperty
  a_rda_irq: assert property (p_rda_irq) else $error("data ready no irq");
  // main scenarios reached
  c_div: cover property (p_div_back);
  c_modem: cover property (ier_sh[3] && irq);
  c_rda: cover property (ier_sh[0] && irq);
endmodule : uhr_uart_props
bind uhr_uart uhr_uart_props u_props (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .ser_out(ser_out), .modem_in(modem_in), .irq(irq));

// >>> tb/uhr_line_partner.sv
// far end of the serial line: captures frames and sends frames
// assumes 8 data bits, one stop bit, first data bit high
`timescale 1ns/10ps
module uhr_line_partner #(
  parameter int BIT_CYC = 1728
) (
  // clock
  input wire logic sys_clk,
  // serial line
  input wire logic ser_out,
  output logic ser_in
);
  logic [7:0] got[$];
  int low_cyc;
  initial ser_in = 1'b1;
  // start bit length measured, then bits sampled mid-cell
  always begin : catch_frame
    logic [7:0] b;
    @(negedge ser_out);
    low_cyc = 0;
    while (ser_out === 1'b0 && low_cyc < 4 * BIT_CYC) begin
      @(posedge sys_clk);
      #1;
      low_cyc++;
    end
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = ser_out;
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    got.push_back(b);
  end
  // one frame out, low bit first, line left idle high
  task send(input logic [7:0] d);
    @(posedge sys_clk);
    #1 ser_in = 1'b0;
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      #1 ser_in = (i < 8) ? d[i] : 1'b1;
    end
    repeat (BIT_CYC) @(posedge sys_clk);
  endtask : send
endmodule : uhr_line_partner

// >>> tb/tb_uhr_uart_register_interface.sv
// self-checking bench for the serial port register block
// assumes the line partner model and the bound checker
`timescale 1ns/10ps
module tb_uart_host_register_interface;
  import uhr_pkg::*;
  localparam int BIT = 16 * UHR_PRESCALE_SYS;
  logic sys_clk, resetn, reg_wr, reg_rd, dma_active, ser_in, ser_out, irq;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [3:0] modem_in, modem_out;
  int num_errors = 0;
  int tests_run = 0;
  uhr_uart dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .dma_active(dma_active), .ser_out(ser_out), .ser_in(ser_in), .modem_in(modem_in),
    .modem_out(modem_out), .irq(irq));
  uhr_line_partner #(.BIT_CYC(BIT)) peer (.sys_clk(sys_clk), .ser_out(ser_out), .ser_in(ser_in));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ****************************************
  // bus cycles and compares
  // ****************************************
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge sys_clk);
    #1 reg_wr = 1'b0;
  endtask : wr
  // read data is taken 1 ns after the edge that samples the strobe
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1 {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge sys_clk);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk8
  task rdc(input logic [2:0] a, input logic [7:0] e, input string nm);
    rd(a, rv);
    chk8(nm, e, rv);
  endtask : rdc
  task test_done;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // ****************************************
  // scenarios
  // ****************************************
  task t_regs;
    rdc(3'h5, 8'h60, "status");
    rdc(3'h2, 8'h01, "ident");
    wr(3'h7, 8'hA5);
    rdc(3'h7, 8'hA5, "scratch");
    wr(3'h1, 8'hFF);
    rdc(3'h1, 8'h0F, "enables");
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h34);
    rdc(3'h0, 8'h34, "divlo");
    wr(3'h1, 8'h12);
    rdc(3'h0, 8'h34, "divlo");
    rdc(3'h1, 8'h12, "divhi");
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h03);
    rdc(3'h1, 8'h00, "enables");
  endtask : t_regs
  // fifo control write held off while dma runs
  task t_dma;
    dma_active = 1'b1;
    wr(3'h2, 8'h01);
    rd(3'h2, rv);
    chk8("fifo on", 8'h00, rv & 8'hC0);
    dma_active = 1'b0;
    wr(3'h2, 8'h01);
    rd(3'h2, rv);
    chk8("fifo on", 8'hC0, rv & 8'hC0);
    wr(3'h2, 8'h00);
  endtask : t_dma
  // two back-to-back characters, modem change before the first start bit
  task t_tx;
    wr(3'h1, 8'h0A);
    wr(3'h0, 8'hA5);
    wr(3'h0, 8'h5B);
    modem_in = 4'h1;
    for (int i = 0; i < 30 * BIT && peer.got.size() < 2; i++) @(posedge sys_clk);
    if (peer.got.size() < 2) begin
      num_errors++;
      test_done();
    end
    chk8("char 1", 8'hA5, peer.got[0]);
    chk8("char 2", 8'h5B, peer.got[1]);
    chk8("bit time", 8'h01, 8'(peer.low_cyc == BIT));
    repeat (BIT) @(posedge sys_clk);
    chk8("irq", 8'h01, {7'h0, irq});
    rdc(3'h2, 8'h02, "ident tx");
    rdc(3'h2, 8'h00, "ident modem");
    rd(3'h6, rv);
    rdc(3'h2, 8'h01, "ident none");
    chk8("irq", 8'h00, {7'h0, irq});
  endtask : t_tx
  task t_rx;
    wr(3'h1, 8'h01);
    peer.send(8'h3C);
    rv = 8'h00;
    for (int i = 0; i < 2 * BIT && rv[0] !== 1'b1; i++) rd(3'h5, rv);
    chk8("ready", 8'h01, rv & 8'h01);
    chk8("irq", 8'h01, {7'h0, irq});
    rdc(3'h2, 8'h04, "ident rx");
    rdc(3'h0, 8'h3C, "rxdata");
    wr(3'h1, 8'h00);
  endtask : t_rx
  initial begin
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, dma_active, modem_in} = '0;
    repeat (6) @(posedge sys_clk);
    #1 resetn = 1'b1;
    t_regs();
    t_dma();
    t_tx();
    t_rx();
    test_done();
  end
endmodule : tb_uart_host_register_interface
